/* File: pasa_top.sv */
// Module: APB-attached audio sample assembler with PWM output and interrupt
`timescale 1ns/1ps
// What this block does
// R1: Eight-bit mode: middle nibble gives sample bits 3 to 0.
// R2: Eight-bit mode: upper nibble gives sample bits 7 to 4.
// R3: Ten-bit option set, twelve-bit clear selects ten-bit resolution.
// R4: Twelve-bit option set always selects twelve-bit resolution.
// R5: Ten-bit mode: extension nibble bits 1 to 0 give sample bits 1 to 0.
// R6: Ten-bit mode: middle nibble gives sample bits 5 to 2.
// R7: Ten-bit mode: upper nibble gives sample bits 9 to 6.
// R8: Twelve-bit mode: extension nibble gives sample bits 3 to 0.
// R9: Twelve-bit mode: middle nibble gives sample bits 7 to 4.
// R10: Twelve-bit mode: upper nibble gives sample bits 11 to 8.
// R11: Top bit of upper nibble is the sign, zero means positive.
// R12: Control bit 0 turns the PWM output on or off.
// R13: Control bit 1 is global interrupt enable; clear blocks interrupts.
// R14: No option set means eight-bit mode, extension nibble ignored.
// R15: PWM disabled holds output idle and stops the duty counter.
module pasa_top
    import pasa_pkg::*;
(
    input  wire logic        clk,         // System clock, 100 MHz
    input  wire logic        rst_b,       // Asynchronous reset, active low
    input  wire logic        psel,        // APB select
    input  wire logic        penable,     // APB enable
    input  wire logic        pwrite,      // APB direction
    input  wire logic [7:0]  paddr,       // APB byte address
    input  wire logic [31:0] pwdata,      // APB write data
    output logic      [31:0] prdata,      // APB read data
    output logic             pready,      // APB ready
    output logic             pslverr,     // APB error
    output logic             pwm_out,     // PWM pin to speaker
    output logic             sample_sign, // Sign of current sample
    output logic             irq          // Level interrupt
);

////////////////////////////////////////////////////////////////////////////////
    logic [3:0]        ext_q;
    logic [3:0]        mid_q;
    logic [3:0]        upper_q;
    logic [1:0]        ctl_q;
    logic [1:0]        opt_q;
    logic [1:0]        sts_q;
    logic [1:0]        mask_q;
    logic [CNT_W-1:0]  cnt_q;
    logic [CNT_W-1:0]  duty_q;
    logic              pwm_q;
    logic              sign_q;
    logic              irq_q;
    logic [31:0]       rdata_q;
    logic              ready_q;
    logic              err_q;
    logic              setup;
    logic              wr_en;
    logic [3:0]        idx;
    logic              hit;
    logic [CNT_W-1:0]  sample_d;
    logic [CNT_W-1:0]  top_d;
    logic              period_end;
    logic              pwm_en;
    logic              gie;
    logic [1:0]        sts_set;
    logic [1:0]        sts_clr;
    pasa_res_t         res;
    logic [1:0]        sts_d;
    logic              rd_en;
    logic              nib_rd;

    assign pwm_en = ctl_q[CTL_PWM_EN_BIT];
    assign gie    = ctl_q[CTL_GIE_BIT];

////////////////////////////////////////////////////////////////////////////////
    // APB slave: one wait-free access, answer in the access cycle after setup
    assign setup = psel & ~penable;
    assign idx   = paddr[5:2];
    assign hit   = (paddr[7:6] == 2'b00) && (paddr[1:0] == 2'b00) &&
                   ((idx == IDX_EXT_NIBBLE) || (idx == IDX_PWM_CONTROL) ||
                    (idx == IDX_MID_NIBBLE) || (idx == IDX_UPPER_NIBBLE) ||
                    (idx == IDX_OPTIONS) || (idx == IDX_IRQ_STATUS) ||
                    (idx == IDX_IRQ_MASK) || (idx == IDX_SAMPLE));
    assign wr_en = setup & pwrite & hit;
    // Read decode, watched by the read checks at the end
    // Writes land at the setup edge, so a read right after sees the new value
    assign rd_en  = setup & ~pwrite & hit;
    assign nib_rd = rd_en & ((idx == IDX_EXT_NIBBLE) || (idx == IDX_MID_NIBBLE) || (idx == IDX_UPPER_NIBBLE));

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ready_q <= 1'b0;
            err_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ready_q <= setup;
            err_q   <= setup & ~hit;
            rdata_q <= 32'h0000_0000;
            // Nibble registers are write-only and read as zero
            if (setup && !pwrite && hit) begin
                unique case (idx)
                    IDX_PWM_CONTROL: rdata_q <= {30'h0, ctl_q};
                    IDX_OPTIONS:     rdata_q <= {30'h0, opt_q};
                    IDX_IRQ_STATUS:  rdata_q <= {30'h0, sts_q};
                    IDX_IRQ_MASK:    rdata_q <= {30'h0, mask_q};
                    IDX_SAMPLE:      rdata_q <= {20'h0, duty_q};
                    default:         rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ext_q   <= RST_NIBBLE;
            mid_q   <= RST_NIBBLE;
            upper_q <= RST_NIBBLE;
            ctl_q   <= RST_CONTROL;
            opt_q   <= RST_OPTIONS;
            mask_q  <= RST_IRQ;
        end else if (wr_en) begin
            unique case (idx)
                IDX_EXT_NIBBLE:   ext_q   <= pwdata[3:0];
                IDX_MID_NIBBLE:   mid_q   <= pwdata[3:0];
                IDX_UPPER_NIBBLE: upper_q <= pwdata[3:0];
                IDX_PWM_CONTROL:  ctl_q   <= pwdata[1:0]; // [R12] [R13]
                IDX_OPTIONS:      opt_q   <= pwdata[1:0];
                IDX_IRQ_MASK:     mask_q  <= pwdata[1:0];
                default:          ;
            endcase
        end
    end

////////////////////////////////////////////////////////////////////////////////
    // Resolution select and sample assembly
    always_comb begin
        if (opt_q[OPT_TWELVE_BIT]) begin
            res = PASA_RES_12; // [R4]
        end else if (opt_q[OPT_TEN_BIT]) begin
            res = PASA_RES_10; // [R3]
        end else begin
            res = PASA_RES_8; // [R14]
        end
    end

    always_comb begin
        sample_d = '0;
        top_d    = '0;
        unique case (res)
            PASA_RES_8: begin
                sample_d = {4'h0, upper_q, mid_q}; // [R1] [R2] [R14]
                top_d    = TOP_RES_8;
            end
            PASA_RES_10: begin
                sample_d = {2'h0, upper_q, mid_q, ext_q[1:0]}; // [R5] [R6] [R7]
                top_d    = TOP_RES_10;
            end
            PASA_RES_12: begin
                sample_d = {upper_q, mid_q, ext_q}; // [R8] [R9] [R10]
                top_d    = TOP_RES_12;
            end
        endcase
    end

////////////////////////////////////////////////////////////////////////////////
    // Duty counter; the new sample is latched at each period boundary so a
    // half-written nibble set never shows mid-period
    // At or above top, so a smaller resolution chosen mid-run cannot strand the count
    assign period_end = (cnt_q >= top_d);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q  <= '0;
            duty_q <= '0;
            pwm_q  <= PWM_IDLE_LEVEL;
            sign_q <= 1'b0;
        end else if (!pwm_en) begin
            cnt_q  <= '0; // [R15]
            pwm_q  <= PWM_IDLE_LEVEL; // [R15]
            duty_q <= sample_d;
            sign_q <= upper_q[3]; // [R11]
        end else begin
            cnt_q <= period_end ? '0 : cnt_q + 12'h001;
            if (period_end) begin
                duty_q <= sample_d;
                sign_q <= upper_q[3]; // [R11]
            end
            // Offset binary: sign bit zero gives the upper half of duty
            pwm_q <= (cnt_q < (duty_q ^ signflip(res))); // [R11]
        end
    end

    function automatic logic [CNT_W-1:0] signflip(input pasa_res_t r);
        unique case (r)
            PASA_RES_8:  signflip = SIGN_RES_8;
            PASA_RES_10: signflip = SIGN_RES_10;
            PASA_RES_12: signflip = SIGN_RES_12;
            default:     signflip = SIGN_RES_12;
        endcase
    endfunction

////////////////////////////////////////////////////////////////////////////////
    // Interrupts: period end and non-zero sample taken; set wins over write-one clear,
    // so an event landing in the clearing cycle is never lost
    always_comb begin
        sts_set                 = 2'h0;
        sts_set[IRQ_PERIOD_BIT] = period_end & pwm_en;
        sts_set[IRQ_SAMPLE_BIT] = period_end & pwm_en & (|sample_d);
    end

    assign sts_clr = (wr_en && idx == IDX_IRQ_STATUS) ? pwdata[1:0] : 2'h0;

    // One sticky flag per event
    for (genvar i = 0; i < 2; i++) begin : g_sts
        assign sts_d[i] = (sts_q[i] & ~sts_clr[i]) | sts_set[i];
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sts_q <= RST_IRQ;
            irq_q <= 1'b0;
        end else begin
            sts_q <= sts_d;
            // Registered so the pin comes from a flip-flop, at one cycle of lag
            irq_q <= gie & |(sts_q & mask_q); // [R13]
        end
    end

    assign prdata      = rdata_q;
    assign pready      = ready_q;
    assign pslverr     = err_q;
    assign pwm_out     = pwm_q;
    assign sample_sign = sign_q;
    assign irq         = irq_q;

////////////////////////////////////////////////////////////////////////////////
    chk_idle_off: assert property (@(posedge clk) disable iff (!rst_b) // [R15]
        !pwm_en |=> (pwm_out == PWM_IDLE_LEVEL) && (cnt_q == '0))
        else $error("PWM not idle while disabled");
    chk_irq_gate: assert property (@(posedge clk) disable iff (!rst_b) // [R13]
        !gie |=> !irq) else $error("Interrupt with global enable clear");
    chk_res_twelve: assert property (@(posedge clk) disable iff (!rst_b) // [R4]
        opt_q[OPT_TWELVE_BIT] |-> res == PASA_RES_12) else $error("Twelve bit not chosen");
    chk_res_ten: assert property (@(posedge clk) disable iff (!rst_b) // [R3]
        opt_q == 2'b01 |-> res == PASA_RES_10) else $error("Ten bit not chosen");
    chk_eight_pack: assert property (@(posedge clk) disable iff (!rst_b) // [R1] [R2] [R14]
        opt_q == 2'b00 |-> sample_d == {4'h0, upper_q, mid_q}) else $error("Eight bit packing wrong");
    chk_ten_pack: assert property (@(posedge clk) disable iff (!rst_b) // [R5] [R6] [R7]
        res == PASA_RES_10 |-> sample_d[9:0] == {upper_q, mid_q, ext_q[1:0]} && sample_d[11:10] == 2'b00)
        else $error("Ten bit packing wrong");
    chk_twelve_pack: assert property (@(posedge clk) disable iff (!rst_b) // [R8] [R9] [R10]
        res == PASA_RES_12 |-> sample_d == {upper_q, mid_q, ext_q}) else $error("Twelve bit packing wrong");
    chk_ctl_write: assert property (@(posedge clk) disable iff (!rst_b) // [R12]
        wr_en && idx == IDX_PWM_CONTROL |=> ctl_q == $past(pwdata[1:0])) else $error("Control write lost");
    chk_sign_track: assert property (@(posedge clk) disable iff (!rst_b) // [R11]
        !pwm_en |=> sample_sign == $past(upper_q[3])) else $error("Sign bit not tracked");
    chk_wait_free: assert property (@(posedge clk) disable iff (!rst_b)
        setup |=> pready) else $error("APB answer late");
    cov_ten_run: cover property (@(posedge clk) disable iff (!rst_b) res == PASA_RES_10 && period_end && pwm_en);
    cov_twelve_run: cover property (@(posedge clk) disable iff (!rst_b) res == PASA_RES_12 && period_end && pwm_en);
    cov_irq: cover property (@(posedge clk) disable iff (!rst_b) irq);
    cov_eight_run: cover property (@(posedge clk) disable iff (!rst_b) res == PASA_RES_8 && period_end && pwm_en);
    cov_set_on_clear: cover property (@(posedge clk) disable iff (!rst_b) (sts_set & sts_clr) != 2'h0);

    // Duty counter: wraps at the period top of the chosen resolution
    chk_period_wrap: assert property (@(posedge clk) disable iff (!rst_b) // [R3] [R4] [R14]
        pwm_en && period_end |=> cnt_q == '0)
        else $error("Duty counter did not wrap");
    chk_count_step: assert property (@(posedge clk) disable iff (!rst_b)
        pwm_en && !period_end |=> cnt_q == $past(cnt_q) + 12'h001)
        else $error("Duty counter skipped a step");
    chk_top_eight: assert property (@(posedge clk) disable iff (!rst_b) // [R14]
        res == PASA_RES_8 |-> top_d == TOP_RES_8)
        else $error("Eight bit period top wrong");
    chk_top_ten: assert property (@(posedge clk) disable iff (!rst_b) // [R3]
        res == PASA_RES_10 |-> top_d == TOP_RES_10)
        else $error("Ten bit period top wrong");
    chk_top_twelve: assert property (@(posedge clk) disable iff (!rst_b) // [R4]
        res == PASA_RES_12 |-> top_d == TOP_RES_12)
        else $error("Twelve bit period top wrong");
    chk_res_eight: assert property (@(posedge clk) disable iff (!rst_b) // [R14]
        opt_q == 2'b00 |-> res == PASA_RES_8)
        else $error("Eight bit not chosen");

    // Sample and sign are taken together, at the period boundary only while PWM runs, every cycle while it is off
    chk_duty_latch: assert property (@(posedge clk) disable iff (!rst_b)
        pwm_en && period_end |=> duty_q == $past(sample_d))
        else $error("Sample not taken at period end");
    chk_duty_hold: assert property (@(posedge clk) disable iff (!rst_b)
        pwm_en && !period_end |=> $stable(duty_q))
        else $error("Sample changed inside a period");
    chk_sign_latch: assert property (@(posedge clk) disable iff (!rst_b) // [R11]
        pwm_en && period_end |=> sample_sign == $past(upper_q[3]))
        else $error("Sign not taken at period end");
    chk_sign_hold: assert property (@(posedge clk) disable iff (!rst_b) // [R11]
        pwm_en && !period_end |=> $stable(sample_sign))
        else $error("Sign changed inside a period");

    // Offset binary: a positive sample stays high over the lower half, a negative low above it
    chk_pos_half: assert property (@(posedge clk) disable iff (!rst_b) // [R11]
        pwm_en && !sample_sign && (cnt_q < signflip(res)) |=> pwm_out)
        else $error("Positive sample low in lower half");
    chk_neg_half: assert property (@(posedge clk) disable iff (!rst_b) // [R11]
        pwm_en && sample_sign && (cnt_q >= signflip(res)) |=> !pwm_out)
        else $error("Negative sample high in upper half");

    // Interrupt flags and level output
    chk_set_wins: assert property (@(posedge clk) disable iff (!rst_b)
        sts_set != 2'h0 |=> (sts_q & $past(sts_set)) == $past(sts_set))
        else $error("Event flag lost");
    chk_w1c_clear: assert property (@(posedge clk) disable iff (!rst_b)
        (sts_clr & ~sts_set) != 2'h0 |=> (sts_q & $past(sts_clr & ~sts_set)) == 2'h0)
        else $error("Flag not cleared by write one");
    chk_period_flag: assert property (@(posedge clk) disable iff (!rst_b)
        pwm_en && period_end |=> sts_q[IRQ_PERIOD_BIT])
        else $error("Period flag not set");
    chk_sample_flag: assert property (@(posedge clk) disable iff (!rst_b)
        pwm_en && period_end && (|sample_d) |=> sts_q[IRQ_SAMPLE_BIT])
        else $error("Sample flag not set");
    chk_irq_raise: assert property (@(posedge clk) disable iff (!rst_b) // [R13]
        gie && (sts_q & mask_q) != 2'h0 |=> irq)
        else $error("Interrupt not raised");
    chk_irq_quiet: assert property (@(posedge clk) disable iff (!rst_b)
        (sts_q & mask_q) == 2'h0 |=> !irq)
        else $error("Interrupt without masked flag");

    // Register bus answers
    chk_ready_pulse: assert property (@(posedge clk) disable iff (!rst_b)
        pready |=> !pready)
        else $error("Ready longer than one cycle");
    chk_unmapped_err: assert property (@(posedge clk) disable iff (!rst_b)
        setup && !hit |=> pslverr && pready)
        else $error("Unmapped access not refused");
    chk_err_ready: assert property (@(posedge clk) disable iff (!rst_b)
        pslverr |-> pready)
        else $error("Error without ready");
    chk_err_no_write: assert property (@(posedge clk) disable iff (!rst_b)
        setup && pwrite && !hit |=> $stable(ctl_q) && $stable(opt_q) && $stable(mask_q))
        else $error("Refused write changed a register");
    chk_nibble_read: assert property (@(posedge clk) disable iff (!rst_b)
        nib_rd |=> prdata == 32'h0000_0000)
        else $error("Write-only nibble read not zero");
    chk_ctl_read: assert property (@(posedge clk) disable iff (!rst_b) // [R12] [R13]
        rd_en && idx == IDX_PWM_CONTROL |=> prdata == {30'h0, $past(ctl_q)})
        else $error("Control readback wrong");
    chk_opt_read: assert property (@(posedge clk) disable iff (!rst_b)
        rd_en && idx == IDX_OPTIONS |=> prdata == {30'h0, $past(opt_q)})
        else $error("Options readback wrong");
    chk_mask_read: assert property (@(posedge clk) disable iff (!rst_b)
        rd_en && idx == IDX_IRQ_MASK |=> prdata == {30'h0, $past(mask_q)})
        else $error("Mask readback wrong");
    chk_status_read: assert property (@(posedge clk) disable iff (!rst_b)
        rd_en && idx == IDX_IRQ_STATUS |=> prdata == {30'h0, $past(sts_q)})
        else $error("Status readback wrong");
    chk_sample_read: assert property (@(posedge clk) disable iff (!rst_b)
        rd_en && idx == IDX_SAMPLE |=> prdata == {20'h0, $past(duty_q)})
        else $error("Sample readback wrong");
    chk_opt_write: assert property (@(posedge clk) disable iff (!rst_b) // [R3] [R4]
        wr_en && idx == IDX_OPTIONS |=> opt_q == $past(pwdata[1:0]))
        else $error("Options write lost");
    chk_mask_write: assert property (@(posedge clk) disable iff (!rst_b)
        wr_en && idx == IDX_IRQ_MASK |=> mask_q == $past(pwdata[1:0]))
        else $error("Mask write lost");
    chk_upper_write: assert property (@(posedge clk) disable iff (!rst_b) // [R2] [R7] [R10]
        wr_en && idx == IDX_UPPER_NIBBLE |=> upper_q == $past(pwdata[3:0]))
        else $error("Upper nibble write lost");
    chk_mid_write: assert property (@(posedge clk) disable iff (!rst_b) // [R1] [R6] [R9]
        wr_en && idx == IDX_MID_NIBBLE |=> mid_q == $past(pwdata[3:0]))
        else $error("Middle nibble write lost");
    chk_ext_write: assert property (@(posedge clk) disable iff (!rst_b) // [R5] [R8]
        wr_en && idx == IDX_EXT_NIBBLE |=> ext_q == $past(pwdata[3:0]))
        else $error("Extension nibble write lost");
endmodule

/* File: pasa_pkg.sv */
// Package: register map, field positions, reset values and timing for the PWM sample assembler
package pasa_pkg;
    // Register indices as printed; byte address is four times the index
    localparam logic [3:0]  IDX_EXT_NIBBLE   = 4'h8;
    localparam logic [3:0]  IDX_PWM_CONTROL  = 4'h9;
    localparam logic [3:0]  IDX_MID_NIBBLE   = 4'hA;
    localparam logic [3:0]  IDX_UPPER_NIBBLE = 4'hB;
    localparam logic [3:0]  IDX_OPTIONS      = 4'h4;
    localparam logic [3:0]  IDX_IRQ_STATUS   = 4'h5;
    localparam logic [3:0]  IDX_IRQ_MASK     = 4'h6;
    localparam logic [3:0]  IDX_SAMPLE       = 4'h7;
    // Control fields
    localparam int          CTL_PWM_EN_BIT   = 0;
    localparam int          CTL_GIE_BIT      = 1;
    // Option fields
    localparam int          OPT_TEN_BIT      = 0;
    localparam int          OPT_TWELVE_BIT   = 1;
    // Interrupt status fields
    localparam int          IRQ_PERIOD_BIT   = 0;
    localparam int          IRQ_SAMPLE_BIT   = 1;
    // Reset values
    localparam logic [3:0]  RST_NIBBLE       = 4'h0;
    localparam logic [1:0]  RST_CONTROL      = 2'h0;
    localparam logic [1:0]  RST_OPTIONS      = 2'h0;
    localparam logic [1:0]  RST_IRQ          = 2'h0;
    // Counter width and idle level of the PWM pin
    localparam int          CNT_W            = 12;
    localparam logic        PWM_IDLE_LEVEL   = 1'b0;
    // Period tops and sign weights of the three resolutions
    localparam logic [CNT_W-1:0] TOP_RES_8   = 12'h0FF;
    localparam logic [CNT_W-1:0] TOP_RES_10  = 12'h3FF;
    localparam logic [CNT_W-1:0] TOP_RES_12  = 12'hFFF;
    localparam logic [CNT_W-1:0] SIGN_RES_8  = 12'h080;
    localparam logic [CNT_W-1:0] SIGN_RES_10 = 12'h200;
    localparam logic [CNT_W-1:0] SIGN_RES_12 = 12'h800;
    typedef enum logic [1:0] {
        PASA_RES_8,
        PASA_RES_10,
        PASA_RES_12
    } pasa_res_t;
endpackage

/* File: pasa_speaker.sv */
// Speaker model: the far side of the PWM pin, counting cycles spent high
`timescale 1ns/1ps
module pasa_speaker (
    input  wire logic clk,       // System clock
    input  wire logic pwm_in,    // PWM pin from the block
    output int        highs      // High cycles seen since start
);
    // A bare cone only averages the pin, so a count is all it keeps
    int count_q = 0;

    always @(posedge clk) begin
        if (pwm_in === 1'b1) begin
            count_q <= count_q + 1;
        end
    end

    assign highs = count_q;
endmodule

/* File: testbench.sv */
// Testbench: APB master, sample assembly model and PWM duty measurement
`timescale 1ns/1ps
module testbench;
    import pasa_pkg::*;
    logic        clk     = 1'b0;
    logic        rst_b   = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready;
    logic        pslverr;
    logic        pwm_out;
    logic        sample_sign;
    logic        irq;
    logic        err;
    logic [3:0]  ext;
    logic [3:0]  mid;
    logic [3:0]  up;
    logic [11:0] smp;
    logic [11:0] duty;
    int          highs;
    int          res;
    int          h0;
    int          errors    = 0;
    int          tests_run = 0;

    always #5 clk = ~clk;

    pasa_top u_pasa_top (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pwm_out(pwm_out), .sample_sign(sample_sign), .irq(irq));
    pasa_speaker u_pasa_speaker (.clk(clk), .pwm_in(pwm_out), .highs(highs));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        check(n < 20, 1, "apb answer");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(9));
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        apb(0, 8'h24, 0);
        check(rd, 0, "control reset value");
        apb(1, 8'h3C, 32'h5);
        check(err, 1, "unmapped error");
        apb(0, 8'h20, 0);
        check(rd, 0, "write-only nibble reads zero");
        for (int opt = 0; opt < 4; opt++) begin
            ext = 4'($urandom);
            mid = 4'($urandom);
            // Alternate the sign so both halves of the offset are seen
            up  = {opt[0], 3'($urandom)};
            apb(1, 8'h10, opt);
            apb(1, 8'h20, {28'h0, ext});
            apb(1, 8'h28, {28'h0, mid});
            apb(1, 8'h2C, {28'h0, up});
            res  = opt[1] ? 12 : (opt[0] ? 10 : 8);
            smp  = (res == 12) ? {up, mid, ext} : (res == 10) ? {2'b0, up, mid, ext[1:0]} : {4'b0, up, mid};
            duty = smp ^ (12'h1 << (res - 1));
            check(pwm_out, 0, "idle while disabled");
            apb(1, 8'h24, 32'h1);
            repeat (5) @(posedge clk);
            h0 = highs;
            repeat (1 << res) @(posedge clk);
            check(highs - h0, duty, "duty over one period");
            check(sample_sign, up[3], "sample sign");
            apb(0, 8'h1C, 0);
            check(rd, smp, "latched sample readback");
            apb(1, 8'h24, 32'h0);
            repeat (3) @(posedge clk);
            check(pwm_out, 0, "output off after disable");
        end
        apb(1, 8'h18, 32'h3);
        apb(1, 8'h14, 32'h3);
        apb(1, 8'h24, 32'h1);
        repeat (4200) @(posedge clk);
        check(irq, 0, "irq held off by global enable");
        apb(1, 8'h24, 32'h3);
        repeat (3) @(posedge clk);
        check(irq, 1, "irq raised");
        apb(0, 8'h14, 0);
        check(rd, 3, "status flags set");
        apb(0, 8'h10, 0);
        check(rd, 3, "options readback");
        apb(0, 8'h24, 0);
        check(rd, 3, "control readback");
        apb(1, 8'h18, 32'h0);
        repeat (3) @(posedge clk);
        check(irq, 0, "irq masked");
        apb(1, 8'h14, 32'h3);
        apb(1, 8'h18, 32'h3);
        repeat (3) @(posedge clk);
        check(irq, 0, "irq cleared");
        print_verdict();
    end

    initial begin
        #1000000;
        errors++;
        print_verdict();
    end
endmodule
